// ---- logic/see_regs.svh ----
// constants for the serial eeprom pin-level slave: opcodes, widths, pin positions, timing
// assumes the includer runs on core_clk at 20 MHz and that the pins reach it asynchronously
// Behaviour
// - select high selects, low gives standby
// - started programming finishes despite select falling
// - select low holds control logic in reset
// - sample input and shift output on rise
// - serial clock may pause at any level
// - ignore clocks deselected or awaiting start
// - programming needs no serial clock cycles
// - execute after exact bit count, then ignore; a read keeps sending the following words while clocks continue
// - read data driven shortly after rising edge
// - status shown until next start bit
// - width pin high sixteen, low eight
// - permit pin low inhibits all programming
// - start is first rise with select, input high
// - status low while busy, high when ready
// - output released when select falls
// - read sends dummy zero before data word
`ifndef SEE_REGS_SVH
`define SEE_REGS_SVH

`define SEE_OP_EXT        2'h0
`define SEE_OP_WRITE      2'h1
`define SEE_OP_READ       2'h2
`define SEE_OP_ERASE      2'h3
`define SEE_SUB_DISABLE   2'h0
`define SEE_SUB_WRITE_ALL 2'h1
`define SEE_SUB_ERASE_ALL 2'h2
`define SEE_SUB_ENABLE    2'h3

`define SEE_OPC_BITS      6'h02
`define SEE_ABITS_X16     6'h0a
`define SEE_ABITS_X8      6'h0b
`define SEE_DBITS_X16     6'h10
`define SEE_DBITS_X8      6'h08
`define SEE_LAST_X16      5'h0f
`define SEE_LAST_X8       5'h07
`define SEE_SR_W          29
`define SEE_MEM_BYTES     2048
`define SEE_IDX_MASK_X16  11'h3ff
`define SEE_IDX_MASK_X8   11'h7ff
`define SEE_ERASED_WORD   16'hffff

`define SEE_SYNC_W        5
`define SEE_PIN_CS        0
`define SEE_PIN_SCLK      1
`define SEE_PIN_DIN       2
`define SEE_PIN_WWS       3
`define SEE_PIN_PERMIT    4

`define SEE_CLK_PERIOD_NS 50
`define SEE_PROG_TIME_MS  3
`define SEE_PROG_CYCLES   ((`SEE_PROG_TIME_MS * 1000000) / `SEE_CLK_PERIOD_NS)

`endif

// ---- logic/see_pkg.sv ----
// types shared by the serial eeprom slave
// assumes see_regs.svh carries every number
package see_pkg;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'h1,
    ST_SHIFT  = 4'h2,
    ST_READ   = 4'h4,
    ST_STATUS = 4'h8
  } see_state_e;

  typedef struct packed {
    logic cs;
    logic sclk;
    logic din;
  } see_pins_s;

  typedef struct packed {
    logic dout;
    logic oe;
  } see_dout_s;

endpackage

// ---- logic/see_sync.sv ----
// two-flop synchroniser for a group of asynchronous pins
// assumes each bit is an independent level; no bus coherence across bits
`timescale 1ns/1ps
module see_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst,
  // pins in, synchronised levels out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  for (genvar i = 0; i < W; i++) begin : g_bit
    logic meta_ff;
    logic hold_ff;
    // the first flop feeds only the second
    always_ff @(posedge core_clk) begin
      if (rst) begin
        meta_ff <= 1'b0;
        hold_ff <= 1'b0;
      end else begin
        meta_ff <= d[i];
        hold_ff <= meta_ff;
      end
    end
    assign q[i] = hold_ff;
  end

endmodule

// ---- logic/see_top.sv ----
// serial eeprom slave: pin decoder, read shifter, self-timed programming engine, array
// assumes select, serial clock and input arrive from another domain and are slow vs core_clk
`timescale 1ns/1ps
`include "see_regs.svh"
module see_top #(
  parameter int PROG_CYCLES = `SEE_PROG_CYCLES
) (
  // clock and reset
  input  wire logic                core_clk,
  input  wire logic                rst,
  // serial link from the master
  input  wire see_pkg::see_pins_s  pins_in,
  output see_pkg::see_dout_s       dout,
  // static straps
  input  wire logic                word_width_select,
  input  wire logic                program_permit_pin,
  // status
  output logic                     busy
);
  import see_pkg::*;

  logic [`SEE_SYNC_W-1:0]  raw;
  logic [`SEE_SYNC_W-1:0]  syn;
  logic                    cs_s;
  logic                    sclk_s;
  logic                    din_s;
  logic                    x16;
  logic                    permit_s;
  logic                    sclk_prev_ff;
  logic                    rise;
  see_state_e              state_ff;
  logic [5:0]              cnt_ff;
  logic [5:0]              nxt_cnt;
  logic [`SEE_SR_W-1:0]    sr_ff;
  logic [`SEE_SR_W-1:0]    nxt_sr;
  logic [1:0]              op_ff;
  logic [1:0]              sub_ff;
  logic                    exec;
  logic                    has_data;
  logic                    is_prog;
  logic                    is_all;
  logic                    start_prog;
  logic [10:0]             addr_sel;
  logic [15:0]             data_sel;
  logic                    ew_en_ff;
  logic                    busy_ff;
  logic [31:0]             pcnt_ff;
  logic                    all_ff;
  logic                    px16_ff;
  logic [11:0]             sw_ff;
  logic [15:0]             pat_ff;
  logic                    prog_done;
  logic                    do_ff;
  logic [15:0]             rdsh_ff;
  logic [4:0]              rcnt_ff;
  logic [10:0]             rd_idx_ff;
  logic [10:0]             idx_mask;
  logic [10:0]             idx_inc;
  logic [15:0]             nxt_word;
  logic [7:0]              mem [0:`SEE_MEM_BYTES-1];

  function automatic logic [5:0] need_bits(input logic [1:0] op, input logic [1:0] sub,
                                           input logic wide);
    logic [5:0] n;
    n = `SEE_OPC_BITS + (wide ? `SEE_ABITS_X16 : `SEE_ABITS_X8);
    if (op == `SEE_OP_WRITE || (op == `SEE_OP_EXT && sub == `SEE_SUB_WRITE_ALL)) begin
      n = n + (wide ? `SEE_DBITS_X16 : `SEE_DBITS_X8);
    end
    return n;
  endfunction

  // pins cross into core_clk before anything looks at them
  assign raw = {program_permit_pin, word_width_select, pins_in.din, pins_in.sclk, pins_in.cs};

  see_sync #(
    .W (`SEE_SYNC_W)
  ) u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .d        (raw),
    .q        (syn)
  );

  assign cs_s     = syn[`SEE_PIN_CS];
  assign sclk_s   = syn[`SEE_PIN_SCLK];
  assign din_s    = syn[`SEE_PIN_DIN];
  assign x16      = syn[`SEE_PIN_WWS];
  assign permit_s = syn[`SEE_PIN_PERMIT];

  // edge found purely from levels, so a stopped clock simply yields no edges
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sclk_prev_ff <= 1'b0;
    end else begin
      sclk_prev_ff <= sclk_s;
    end
  end
  assign rise = sclk_s & ~sclk_prev_ff;

  assign nxt_cnt  = cnt_ff + 6'h01;
  assign nxt_sr   = {sr_ff[`SEE_SR_W-2:0], din_s};
  assign has_data = (op_ff == `SEE_OP_WRITE) ||
                    (op_ff == `SEE_OP_EXT && sub_ff == `SEE_SUB_WRITE_ALL);
  assign is_all   = (op_ff == `SEE_OP_EXT) &&
                    (sub_ff == `SEE_SUB_ERASE_ALL || sub_ff == `SEE_SUB_WRITE_ALL);
  assign is_prog  = (op_ff == `SEE_OP_WRITE) || (op_ff == `SEE_OP_ERASE) || is_all;
  // the count can only match once the opcode is known, since it is at least twelve
  assign exec = (state_ff == ST_SHIFT) && cs_s && rise &&
                (nxt_cnt == need_bits(op_ff, sub_ff, x16));
  assign start_prog = exec && is_prog && ew_en_ff && permit_s;

  always_comb begin
    case ({x16, has_data})
      2'b11:   addr_sel = {1'b0, nxt_sr[25:16]};
      2'b10:   addr_sel = {1'b0, nxt_sr[9:0]};
      2'b01:   addr_sel = nxt_sr[18:8];
      default: addr_sel = nxt_sr[10:0];
    endcase
  end
  assign data_sel = x16 ? nxt_sr[15:0] : {8'h00, nxt_sr[7:0]};

  // control state; select low is its reset
  always_ff @(posedge core_clk) begin
    if (rst || !cs_s) begin
      state_ff <= ST_IDLE;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (busy_ff) begin
            state_ff <= ST_STATUS;
          end else if (rise && din_s) begin
            state_ff <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (exec) begin
            if (op_ff == `SEE_OP_READ) begin
              state_ff <= ST_READ;
            end else if (start_prog) begin
              state_ff <= ST_STATUS;
            end else begin
              state_ff <= ST_IDLE;
            end
          end
        end
        ST_READ: begin
          state_ff <= ST_READ;
        end
        ST_STATUS: begin
          // a start while still busy is not honoured
          if (rise && din_s && !busy_ff) begin
            state_ff <= ST_SHIFT;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // instruction shifter
  always_ff @(posedge core_clk) begin
    if (rst || !cs_s || state_ff != ST_SHIFT) begin
      cnt_ff <= 6'h00;
      sr_ff  <= '0;
      op_ff  <= 2'h0;
      sub_ff <= 2'h0;
    end else if (rise) begin
      cnt_ff <= nxt_cnt;
      sr_ff  <= nxt_sr;
      if (nxt_cnt == 6'h02) begin
        op_ff <= {sr_ff[0], din_s};
      end
      if (nxt_cnt == 6'h04) begin
        sub_ff <= {sr_ff[0], din_s};
      end
    end
  end

  // enable latch survives deselect; only reset or a disable clears it
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ew_en_ff <= 1'b0;
    end else if (exec && op_ff == `SEE_OP_EXT && sub_ff == `SEE_SUB_ENABLE) begin
      ew_en_ff <= 1'b1;
    end else if (exec && op_ff == `SEE_OP_EXT && sub_ff == `SEE_SUB_DISABLE) begin
      ew_en_ff <= 1'b0;
    end
  end

  // programming engine runs on core_clk alone and ignores select
  assign prog_done = (pcnt_ff == 32'h0) && (!all_ff || sw_ff[11]);
  always_ff @(posedge core_clk) begin
    if (rst) begin
      busy_ff <= 1'b0;
      pcnt_ff <= 32'h0;
      all_ff  <= 1'b0;
      px16_ff <= 1'b0;
      sw_ff   <= 12'h000;
      pat_ff  <= 16'h0000;
    end else if (start_prog) begin
      busy_ff <= 1'b1;
      pcnt_ff <= PROG_CYCLES[31:0];
      all_ff  <= is_all;
      px16_ff <= x16;
      sw_ff   <= 12'h000;
      pat_ff  <= has_data ? data_sel : `SEE_ERASED_WORD;
    end else if (busy_ff) begin
      if (pcnt_ff != 32'h0) begin
        pcnt_ff <= pcnt_ff - 32'h1;
      end
      if (all_ff && !sw_ff[11]) begin
        sw_ff <= sw_ff + 12'h001;
      end
      if (prog_done) begin
        busy_ff <= 1'b0;
      end
    end
  end

  // array has no reset; contents are undefined until programmed
  always_ff @(posedge core_clk) begin
    if (start_prog && !is_all) begin
      if (x16) begin
        mem[{addr_sel[9:0], 1'b0}] <= has_data ? data_sel[15:8] : 8'hff;
        mem[{addr_sel[9:0], 1'b1}] <= has_data ? data_sel[7:0] : 8'hff;
      end else begin
        mem[addr_sel] <= has_data ? data_sel[7:0] : 8'hff;
      end
    end else if (busy_ff && all_ff && !sw_ff[11]) begin
      mem[sw_ff[10:0]] <= (px16_ff && !sw_ff[0]) ? pat_ff[15:8] : pat_ff[7:0];
    end
  end

  assign idx_mask = x16 ? `SEE_IDX_MASK_X16 : `SEE_IDX_MASK_X8;
  assign idx_inc  = (rd_idx_ff + 11'h001) & idx_mask;
  assign nxt_word = x16 ? {mem[{idx_inc[9:0], 1'b0}], mem[{idx_inc[9:0], 1'b1}]}
                        : {mem[idx_inc], 8'h00};

  // output bit: dummy zero, then words back to back while clocks continue
  always_ff @(posedge core_clk) begin
    if (rst || !cs_s) begin
      do_ff     <= 1'b0;
      rdsh_ff   <= 16'h0000;
      rcnt_ff   <= 5'h00;
      rd_idx_ff <= 11'h000;
    end else if (exec) begin
      do_ff     <= 1'b0;
      rcnt_ff   <= 5'h00;
      rd_idx_ff <= (addr_sel - 11'h001) & idx_mask;
    end else if (state_ff == ST_STATUS) begin
      do_ff <= ~busy_ff;
    end else if (state_ff == ST_READ && rise) begin
      if (rcnt_ff == 5'h00) begin
        do_ff     <= nxt_word[15];
        rdsh_ff   <= {nxt_word[14:0], 1'b0};
        rcnt_ff   <= x16 ? `SEE_LAST_X16 : `SEE_LAST_X8;
        rd_idx_ff <= idx_inc;
      end else begin
        do_ff   <= rdsh_ff[15];
        rdsh_ff <= {rdsh_ff[14:0], 1'b0};
        rcnt_ff <= rcnt_ff - 5'h01;
      end
    end
  end

  assign dout.dout = do_ff;
  assign dout.oe   = (state_ff == ST_READ) || (state_ff == ST_STATUS);
  assign busy      = busy_ff;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  cs_low_idle_a: assert property (!cs_s |=> state_ff == ST_IDLE && !dout.oe)
    else $error("control logic not held idle while deselected");
  oe_release_a: assert property ($fell(cs_s) |=> !dout.oe)
    else $error("output still driven after select fell");
  prog_runs_a: assert property (busy_ff && pcnt_ff > 32'h1 |=> busy_ff)
    else $error("programming ended before its count ran out");
  prog_len_a: assert property ($rose(busy_ff) |-> pcnt_ff == PROG_CYCLES[31:0])
    else $error("programming count not loaded at start");
  start_seen_a: assert property (state_ff == ST_IDLE && !busy_ff && cs_s && rise && din_s
                                 |=> state_ff == ST_SHIFT)
    else $error("start condition missed");
  idle_quiet_a: assert property (state_ff == ST_IDLE && !busy_ff && !(rise && din_s)
                                 |=> state_ff == ST_IDLE)
    else $error("state left idle without a start");
  status_level_a: assert property (state_ff == ST_STATUS && cs_s
                                   |=> dout.dout == !$past(busy_ff))
    else $error("status level does not match busy");
  dummy_zero_a: assert property ($rose(state_ff == ST_READ) |-> dout.dout == 1'b0)
    else $error("read did not begin with a zero bit");
  read_hold_a: assert property (state_ff == ST_READ && cs_s && !rise |=> $stable(dout.dout))
    else $error("read data changed without a clock edge");
  permit_block_a: assert property (exec && is_prog && !permit_s |=> !busy_ff)
    else $error("programming started with permit low");
  read_len_a: assert property ($rose(state_ff == ST_READ)
                               |-> $past(cnt_ff) == ($past(x16) ? 6'h0b : 6'h0c))
    else $error("read executed after the wrong bit count");

endmodule

// ---- dv/see_master.sv ----
// serial bus master model driving select, serial clock and data into the slave
// assumes core_clk at 20 MHz; pins change only at falling core_clk edges
`timescale 1ns/1ps
module see_master (
  // clock
  input  wire logic         core_clk,
  // pins toward the slave
  output see_pkg::see_pins_s pins
);
  import see_pkg::*;
  event smp;
  initial pins = '0;
  // one serial clock of 400 to 500 ns; the low half is stretched at random
  task automatic tick(input logic b, input logic rd);
    pins.din  = b;
    pins.sclk = 1'b0;
    repeat (4 + ($urandom % 3)) @(negedge core_clk);
    if (rd) ->smp;
    pins.sclk = 1'b1;
    repeat (4) @(negedge core_clk);
  endtask
  task automatic frame(input logic [28:0] bits, input int n, input int nrd, input int pre);
    pins.cs = 1'b1;
    repeat (2) @(negedge core_clk);
    for (int i = 0; i < pre; i++) tick(1'b0, 1'b0);
    tick(1'b1, 1'b0);
    for (int i = n - 1; i >= 0; i--) tick(bits[i], 1'b0);
    for (int i = 0; i < nrd; i++) tick(1'($urandom), 1'b1);
    // serial clock is left standing low at the end of each frame
    pins.sclk = 1'b0;
  endtask
  task automatic deselect();
    pins.cs  = 1'b0;
    pins.din = ~pins.din;
    repeat (6) @(negedge core_clk);
  endtask
endmodule

// ---- dv/see_top_test.sv ----
// self-checking bench for the serial eeprom slave, short programming time
// assumes see_master drives the pins; straps driven directly by the bench, each taken to both levels
`timescale 1ns/1ps
`include "see_regs.svh"
module see_top_test;
  import see_pkg::*;
  localparam int PC = 20;
  logic        core_clk;
  logic        rst;
  logic        wws;
  logic        permit;
  logic        busy;
  see_pins_s   pins;
  see_dout_s   dout;
  logic        do_bus;
  int          failures;
  int          n_compared;
  logic        q[$];
  logic [15:0] d0;
  logic [15:0] d1;

  see_top #(.PROG_CYCLES(PC)) i_see_top (.core_clk(core_clk), .rst(rst), .pins_in(pins),
    .dout(dout), .word_width_select(wws), .program_permit_pin(permit), .busy(busy));
  see_master i_see_master (.core_clk(core_clk), .pins(pins));

  // the output line has no pull-up; a released line shows the inverse so it cannot pass
  assign do_bus = dout.oe ? dout.dout : ~dout.dout;

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic cmp_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: read bit %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_val(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: status %h expected %h", $time, got, exp);
    end
  endtask

  // read stream watcher: each sample point takes the oldest noted bit
  always @(i_see_master.smp) begin
    cmp_val(dout.oe, 1'b1);
    if (q.size() > 0) cmp_bit(do_bus, q.pop_front());
  end

  function automatic logic [10:0] ea(input logic [1:0] s);
    ea = wws ? {1'b0, s, 8'h00} : {s, 9'h000};
  endfunction

  task automatic instr(input logic [1:0] op, input logic [10:0] a, input logic [15:0] d,
                       input int nrd);
    logic [28:0] b;
    int          aw;
    int          n;
    aw = wws ? 10 : 11;
    b  = (29'(op) << aw) | 29'(a & (wws ? `SEE_IDX_MASK_X16 : `SEE_IDX_MASK_X8));
    n  = 2 + aw;
    if (op == `SEE_OP_WRITE || (op == `SEE_OP_EXT &&
        (wws ? a[9:8] : a[10:9]) == `SEE_SUB_WRITE_ALL)) begin
      b = (b << (wws ? 16 : 8)) | 29'(wws ? d : {8'h00, d[7:0]});
      n = n + (wws ? 16 : 8);
    end
    i_see_master.frame(b, n, nrd, $urandom % 4);
  endtask

  task automatic quit();
    i_see_master.deselect();
    cmp_val(dout.oe, 1'b0);
  endtask

  task automatic rd(input logic [10:0] a, input logic [15:0] w0, input logic [15:0] w1,
                    input int k);
    int dw;
    dw = wws ? 16 : 8;
    q.push_back(1'b0);
    for (int i = dw - 1; i >= 0; i--) q.push_back(w0[i]);
    if (k > 1) for (int i = dw - 1; i >= 0; i--) q.push_back(w1[i]);
    instr(`SEE_OP_READ, a, 16'h0000, 1 + dw * k);
    quit();
    // every noted bit must have been taken by a sample point
    cmp_val(1'(q.size() == 0), 1'b1);
  endtask

  task automatic prog(input logic [1:0] op, input logic [10:0] a, input logic [15:0] d,
                      input logic ok);
    instr(op, a, d, 0);
    repeat (6) @(negedge core_clk);
    cmp_val(busy, ok);
    cmp_val(dout.oe, ok);
    if (ok) begin
      cmp_val(do_bus, 1'b0);
      for (int i = 0; i < 3000 && do_bus !== 1'b1; i++) @(negedge core_clk);
      // status must survive clocks that carry no start bit
      i_see_master.tick(1'b0, 1'b0);
      cmp_val(do_bus, 1'b1);
      cmp_val(busy, 1'b0);
    end
    quit();
  endtask

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    #3000000;
    failures++;
    summarize();
  end

  initial begin
    rst = 1'b1;
    wws = 1'b1;
    permit = 1'b1;
    failures = 0;
    n_compared = 0;
    void'($urandom(32'h7073b888));
    repeat (3) @(negedge core_clk);
    rst = 1'b0;
    repeat (4) @(negedge core_clk);
    d0 = 16'($urandom);
    d1 = 16'($urandom);
    instr(`SEE_OP_EXT, ea(`SEE_SUB_ENABLE), 16'h0000, 0);
    quit();
    prog(`SEE_OP_WRITE, 11'h3ff, d0, 1'b1);
    prog(`SEE_OP_WRITE, 11'h000, d1, 1'b1);
    rd(11'h3ff, d0, d1, 2);
    $display("test wide write and wrapping read done");
    permit = 1'b0;
    repeat (4) @(negedge core_clk);
    prog(`SEE_OP_WRITE, 11'h3ff, ~d0, 1'b0);
    permit = 1'b1;
    rd(11'h3ff, d0, d0, 1);
    $display("test permit pin inhibit done");
    instr(`SEE_OP_WRITE, 11'h000, ~d1, 0);
    repeat (6) @(negedge core_clk);
    quit();
    cmp_val(busy, 1'b1);
    for (int i = 0; i < 3000 && busy !== 1'b0; i++) @(negedge core_clk);
    rd(11'h000, ~d1, d1, 1);
    // select dropped before the data is complete: nothing may be programmed
    i_see_master.frame(29'({2'b01, 10'h000, 8'ha5}), 20, 0, 0);
    quit();
    cmp_val(busy, 1'b0);
    prog(`SEE_OP_ERASE, 11'h000, 16'h0000, 1'b1);
    rd(11'h000, `SEE_ERASED_WORD, d0, 1);
    instr(`SEE_OP_EXT, ea(`SEE_SUB_DISABLE), 16'h0000, 0);
    quit();
    prog(`SEE_OP_WRITE, 11'h3ff, ~d0, 1'b0);
    $display("test cut select, erase and disable done");
    wws = 1'b0;
    repeat (4) @(negedge core_clk);
    instr(`SEE_OP_EXT, ea(`SEE_SUB_ENABLE), 16'h0000, 0);
    quit();
    prog(`SEE_OP_WRITE, 11'h7ff, d1, 1'b1);
    rd(11'h7ff, d1, d1, 1);
    prog(`SEE_OP_EXT, ea(`SEE_SUB_ERASE_ALL), 16'h0000, 1'b1);
    rd(11'h123, 16'h00ff, d1, 1);
    prog(`SEE_OP_EXT, ea(`SEE_SUB_WRITE_ALL), d0, 1'b1);
    rd(11'h005, d0, d0, 1);
    $display("test narrow words and whole array done");
    summarize();
  end
endmodule
